//--- design/hma_alert_combiner.sv
// What this block does
// - request inputs work only with channel mode bit 7 low and own enable
// - an enabled active request asserts the alert without any status bit
// - at loop completion voltage and fan errors set their status bits
// - a set status bit reaches the alert only with its mask bit zero
// - reading voltage/fan status clears it; still-bad quantities set again
// - status bits other than remote stay set after the quantity returns within limits
// - internal temperature above high or below low limit sets status
// - temperature staying past the same limit sets status, raises no alert
// - new temperature alert on opposite crossing, limit change, or other source
// - internal and both remote temperatures compared with hardware limits
// - lock bits protect the A hardware limits until re-initialize or power cycle; B limits stay writable
// - hardware limit alert ignores status reads; cleared by enable or clear
// - external low on overtemp pin sets status; re-set after next loop
// - external low goes unseen while our own overtemp output drives low
// - status read returns then clears; stays clear until the loop updates
// - two copy registers show status without clearing it
// - masks map one-to-one; status sets and clears regardless of mask
// - alert driven only while the global alert enable is set
// - alert clear bit forces alert off and halts the monitoring loop
// - thermal mask keeps thermal status updating but off the alert
// - request inputs 0 to 2 are active low
// - request inputs 3 and 4 are active high and need config two enables
// - remote errors need three bad readings; one good reading clears
`timescale 1ns/1ps
module hma_alert_combiner
  import hma_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register access port
  input wire hma_req_s req,
  output logic [7:0] regRdata,
  // conversion loop results and halt request
  input wire hma_conv_s conv,
  output logic loopHalt,
  // external pins
  input wire logic [4:0] extRequestInputs,
  input wire logic overtempPinNIn,
  input wire logic overtempOwnDrive,
  // alert toward the host
  output logic alertN
);

  logic [7:0] hwIntA;
  logic [7:0] hwExtA;
  logic [7:0] chMode;
  logic [7:0] hwIntB;
  logic [7:0] hwExtB;
  logic [7:0] tempHi;
  logic [7:0] tempLo;
  logic [7:0] cfgOne;
  logic [7:0] cfgTwo;
  logic [7:0] mask1;
  logic [7:0] mask2;
  logic [7:0] status1;
  logic [7:0] status2;
  logic [1:0] tempSide;
  logic limChanged;
  logic tempPend;
  logic thermArm;
  logic hwAlert;
  logic [1:0] fqFirst;
  logic [1:0] fqSecond;

  // signed temperature compare, used for every limit
  function automatic logic tempAbove(input logic [7:0] a, input logic [7:0] b);
    tempAbove = $signed(a) > $signed(b);
  endfunction : tempAbove

  // saturating fault queue step
  function automatic logic [1:0] fqStep(input logic [1:0] c, input logic bad);
    if (!bad)
      fqStep = 2'h0;
    else if (c == FQ_DEPTH)
      fqStep = c;
    else
      fqStep = c + 2'h1;
  endfunction : fqStep

  // access decode
  logic reinit;
  logic rdStat1;
  logic rdStat2;
  logic loopEvt;
  assign reinit = req.wr && req.addr == ADDR_CFG_ONE && req.wdata[C1_REINIT];
  assign rdStat1 = req.rd && req.addr == ADDR_STAT_1;
  assign rdStat2 = req.rd && req.addr == ADDR_STAT_2;
  // a loop completion is ignored while the clear bit halts the loop
  assign loopEvt = conv.loopDone && !cfgOne[C1_ALERT_CLR];

  // internal temperature against its high/low limits
  logic outHigh;
  logic outLow;
  logic newTempEvt;
  assign outHigh = tempAbove(conv.intTemp, tempHi);
  assign outLow = tempAbove(tempLo, conv.intTemp);
  // a repeat of the same side with unchanged limits only re-sets status, never a new alert
  assign newTempEvt = loopEvt && (outHigh || outLow)
    && ({outLow, outHigh} != tempSide || limChanged);

  // remote fault queues reach depth only after three bad readings
  logic remFirstQual;
  logic remSecondQual;
  assign remFirstQual = fqStep(fqFirst, conv.remOut[0]) == FQ_DEPTH;
  assign remSecondQual = fqStep(fqSecond, conv.remOut[1]) == FQ_DEPTH;

  // hardware limits: internal vs both internal, each remote vs both external
  logic hwHit;
  logic hwClr;
  assign hwHit = loopEvt && (tempAbove(conv.intTemp, hwIntA)
    || tempAbove(conv.intTemp, hwIntB)
    || tempAbove(conv.remFirstTemp, hwExtA)
    || tempAbove(conv.remFirstTemp, hwExtB)
    || tempAbove(conv.remSecondTemp, hwExtA)
    || tempAbove(conv.remSecondTemp, hwExtB));
  assign hwClr = !cfgTwo[C2_TH_INT_EN] || cfgOne[C1_ALERT_CLR]
    || !cfgOne[C1_ALERT_EN] || reinit;

  // external pull-down, unseen under own drive; a read must beat a held pin
  logic thermSet;
  assign thermSet = thermArm && !rdStat2 && !overtempPinNIn
    && !overtempOwnDrive;

  // configuration and limit registers; re-initialize restores all of them
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      hwIntA <= RST_HW_INT;
      hwExtA <= RST_HW_EXT;
      chMode <= RST_CH_MODE;
      hwIntB <= RST_HW_INT;
      hwExtB <= RST_HW_EXT;
      tempHi <= RST_TEMP_HI;
      tempLo <= RST_TEMP_LO;
      cfgOne <= RST_CFG_ONE;
      cfgTwo <= RST_CFG_TWO;
      mask1 <= RST_MASK;
      mask2 <= RST_MASK;
    end
    else if (reinit)
    begin
      // the only way short of power loss to drop the locks
      hwIntA <= RST_HW_INT;
      hwExtA <= RST_HW_EXT;
      chMode <= RST_CH_MODE;
      hwIntB <= RST_HW_INT;
      hwExtB <= RST_HW_EXT;
      tempHi <= RST_TEMP_HI;
      tempLo <= RST_TEMP_LO;
      cfgOne <= RST_CFG_ONE;
      cfgTwo <= RST_CFG_TWO;
      mask1 <= RST_MASK;
      mask2 <= RST_MASK;
    end
    else if (req.wr)
    begin
      case (req.addr)
        ADDR_HW_INT_A:
          if (!cfgTwo[C2_LOCK_INT])
            hwIntA <= req.wdata;
        ADDR_HW_EXT_A:
          if (!cfgTwo[C2_LOCK_EXT])
            hwExtA <= req.wdata;
        ADDR_CH_MODE: chMode <= req.wdata;
        ADDR_HW_INT_B: hwIntB <= req.wdata;
        ADDR_HW_EXT_B: hwExtB <= req.wdata;
        ADDR_TEMP_HI: tempHi <= req.wdata;
        ADDR_TEMP_LO: tempLo <= req.wdata;
        ADDR_CFG_ONE: cfgOne <= req.wdata;
        // lock bits can be set by software but never cleared by it
        ADDR_CFG_TWO: cfgTwo <= req.wdata | (cfgTwo & C2_LOCK_MASK);
        ADDR_STAT_1: mask1 <= req.wdata;
        ADDR_STAT_2: mask2 <= req.wdata;
        default: ;
      endcase
    end
  end

  // status registers: loop sets, read clears, a loop set in the same cycle wins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      status1 <= 8'h00;
      status2 <= 8'h00;
    end
    else
    begin
      status1 <= ((rdStat1 ? 8'h00 : status1)
        & ~{loopEvt && !conv.remOut[0], 7'h00})
        | (loopEvt ? {remFirstQual, outHigh || outLow,
        conv.vfErr[ST_VF_W-1:0]} : 8'h00);
      status2 <= ((rdStat2 ? 8'h00 : status2)
        & ~{loopEvt && !conv.remOut[1], 7'h00})
        | {loopEvt && remSecondQual, thermSet,
        loopEvt ? conv.vfErr[2*ST_VF_W-1:ST_VF_W] : 6'h00};
    end
  end

  // remote fault queues advance once per completed loop
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      fqFirst <= 2'h0;
      fqSecond <= 2'h0;
    end
    else if (loopEvt)
    begin
      fqFirst <= fqStep(fqFirst, conv.remOut[0]);
      fqSecond <= fqStep(fqSecond, conv.remOut[1]);
    end
  end

  // temperature side memory and pending new-crossing alert
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tempSide <= 2'h0;
      limChanged <= 1'b0;
      tempPend <= 1'b0;
    end
    else
    begin
      if (loopEvt)
        tempSide <= {outLow, outHigh};
      // a rewritten limit re-arms the alert for the next conversion
      if (req.wr && (req.addr == ADDR_TEMP_HI || req.addr == ADDR_TEMP_LO))
        limChanged <= 1'b1;
      else if (loopEvt || reinit)
        limChanged <= 1'b0;
      if (newTempEvt)
        tempPend <= 1'b1;
      else if (rdStat1 || reinit)
        tempPend <= 1'b0;
    end
  end

  // overtemp input re-arms only at loop completion after a read
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      thermArm <= 1'b1;
    else if (loopEvt)
      thermArm <= 1'b1;
    else if (rdStat2)
      thermArm <= 1'b0;
  end

  // hardware limit alert: status reads have no effect on it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      hwAlert <= 1'b0;
    else if (hwClr)
      hwAlert <= 1'b0;
    else if (hwHit)
      hwAlert <= 1'b1;
  end

  // pending sources; masks only gate, never touch status
  logic [4:0] reqActive;
  logic [4:0] reqEnable;
  logic reqHit;
  logic pendVf;
  logic pendThermal;
  logic anyPend;
  assign reqActive = {extRequestInputs[4:3],
    ~extRequestInputs[2:0]};
  assign reqEnable = {chMode[4] && cfgTwo[C2_REQ4_EN],
    chMode[3] && cfgTwo[C2_REQ3_EN], chMode[2:0]};
  assign reqHit = !chMode[CM_REQ_OFF]
    && |(reqActive & reqEnable);
  assign pendVf = |(status1[ST_VF_W-1:0] & ~mask1[ST_VF_W-1:0])
    || |(status2[ST_VF_W-1:0] & ~mask2[ST_VF_W-1:0]);
  assign pendThermal = (tempPend && status1[S1_INT_TEMP]
    && !mask1[S1_INT_TEMP])
    || (status1[S1_REM_FIRST] && !mask1[S1_REM_FIRST])
    || (status2[S2_REM_SECOND] && !mask2[S2_REM_SECOND])
    || (status2[S2_OVERTEMP_IN] && !mask2[S2_OVERTEMP_IN])
    || hwAlert;
  assign anyPend = reqHit || pendVf
    || (pendThermal && !cfgTwo[C2_TH_MASK]);

  // alert and halt outputs straight from flops
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      alertN <= 1'b1;
      loopHalt <= 1'b0;
    end
    else
    begin
      alertN <= !(cfgOne[C1_ALERT_EN] && !cfgOne[C1_ALERT_CLR]
        && anyPend);
      loopHalt <= cfgOne[C1_ALERT_CLR];
    end
  end

  // read data, one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      regRdata <= 8'h00;
    else if (req.rd)
    begin
      case (req.addr)
        ADDR_HW_INT_A: regRdata <= hwIntA;
        ADDR_HW_EXT_A: regRdata <= hwExtA;
        ADDR_CH_MODE: regRdata <= chMode;
        ADDR_HW_INT_B: regRdata <= hwIntB;
        ADDR_HW_EXT_B: regRdata <= hwExtB;
        ADDR_TEMP_HI: regRdata <= tempHi;
        ADDR_TEMP_LO: regRdata <= tempLo;
        ADDR_CFG_ONE: regRdata <= cfgOne;
        ADDR_CFG_TWO: regRdata <= cfgTwo;
        ADDR_STAT_1: regRdata <= status1;
        ADDR_STAT_2: regRdata <= status2;
        ADDR_COPY_1: regRdata <= status1;
        ADDR_COPY_2: regRdata <= status2;
        default: regRdata <= 8'h00;
      endcase
    end
  end

  // checks
  sequence reqLowSeq;
    !chMode[CM_REQ_OFF] && chMode[0] && !extRequestInputs[0];
  endsequence
  sequence alertOpenSeq;
    cfgOne[C1_ALERT_EN] && !cfgOne[C1_ALERT_CLR];
  endsequence

  req_alert_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    reqLowSeq and alertOpenSeq |=> !alertN)
    else $error("enabled low request did not assert alert");

  enable_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !cfgOne[C1_ALERT_EN] |=> alertN)
    else $error("alert driven while disabled");

  clear_force_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfgOne[C1_ALERT_CLR] && !req.wr ##1 !req.wr |=> alertN && loopHalt)
    else $error("clear bit did not force alert off and halt loop");

  read_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    rdStat1 && !conv.loopDone |=> status1 == 8'h00)
    else $error("status one not cleared by read");

  copy_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.rd && req.addr == ADDR_COPY_1 && !conv.loopDone
    |=> status1 == $past(status1))
    else $error("copy read changed status");

  lock_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfgTwo[C2_LOCK_INT] && req.wr && req.addr == ADDR_HW_INT_A
    |=> $stable(hwIntA))
    else $error("locked limit was rewritten");

  fault_queue_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(status1[S1_REM_FIRST]) |-> fqFirst == FQ_DEPTH)
    else $error("remote status set before three bad readings");

  hw_sticky_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    hwAlert && !hwClr && rdStat1 |=> hwAlert)
    else $error("hardware alert cleared by status read");

  own_drive_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    overtempOwnDrive && !status2[S2_OVERTEMP_IN] |=> !status2[S2_OVERTEMP_IN])
    else $error("overtemp input sensed during own drive");

  overtemp_pin_n_mask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfgTwo[C2_TH_MASK] && !reqHit && !pendVf |=> alertN)
    else $error("thermal source reached alert while masked");

endmodule : hma_alert_combiner

//--- design/hma_pkg.sv
package hma_pkg;

  // register offsets
  localparam logic [7:0] ADDR_HW_INT_A = 8'h13;
  localparam logic [7:0] ADDR_HW_EXT_A = 8'h14;
  localparam logic [7:0] ADDR_CH_MODE = 8'h16;
  localparam logic [7:0] ADDR_HW_INT_B = 8'h17;
  localparam logic [7:0] ADDR_HW_EXT_B = 8'h18;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h39;
  localparam logic [7:0] ADDR_TEMP_LO = 8'h3A;
  localparam logic [7:0] ADDR_CFG_ONE = 8'h40;
  localparam logic [7:0] ADDR_STAT_1 = 8'h43;
  localparam logic [7:0] ADDR_STAT_2 = 8'h44;
  localparam logic [7:0] ADDR_CFG_TWO = 8'h4A;
  localparam logic [7:0] ADDR_COPY_1 = 8'h4C;
  localparam logic [7:0] ADDR_COPY_2 = 8'h4D;

  // channel mode fields: request enables in bits 4..0
  localparam int CM_REQ_OFF = 7;
  // configuration one fields
  localparam int C1_ALERT_EN = 1;
  localparam int C1_ALERT_CLR = 3;
  localparam int C1_REINIT = 7;
  // configuration two fields
  localparam int C2_TH_MASK = 0;
  localparam int C2_LOCK_INT = 1;
  localparam int C2_LOCK_EXT = 2;
  localparam int C2_REQ3_EN = 4;
  localparam int C2_REQ4_EN = 5;
  localparam int C2_TH_INT_EN = 6;
  localparam logic [7:0] C2_LOCK_MASK = 8'h06;

  // status fields; bits 5..0 of both hold voltage and fan errors
  localparam int ST_VF_W = 6;
  localparam int S1_INT_TEMP = 6;
  localparam int S1_REM_FIRST = 7;
  localparam int S2_OVERTEMP_IN = 6;
  localparam int S2_REM_SECOND = 7;

  // values after reset or re-initialize
  localparam logic [7:0] RST_HW_INT = 8'h46;
  localparam logic [7:0] RST_HW_EXT = 8'h55;
  localparam logic [7:0] RST_CH_MODE = 8'h00;
  localparam logic [7:0] RST_TEMP_HI = 8'h7F;
  localparam logic [7:0] RST_TEMP_LO = 8'h80;
  localparam logic [7:0] RST_CFG_ONE = 8'h00;
  localparam logic [7:0] RST_CFG_TWO = 8'h40;
  localparam logic [7:0] RST_MASK = 8'h00;

  // remote readings out of limits in a row before status sets
  localparam logic [1:0] FQ_DEPTH = 2'h3;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hma_req_s;

  typedef struct packed {
    logic loopDone;
    logic [11:0] vfErr;
    logic [7:0] intTemp;
    logic [7:0] remFirstTemp;
    logic [7:0] remSecondTemp;
    logic [1:0] remOut;
  } hma_conv_s;

endpackage : hma_pkg

//--- testbench/hma_loop_model.sv
`timescale 1ns/1ps
module hma_loop_model
  import hma_pkg::*;
#(
  parameter int GAP = 16
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // loop control and measured values
  input wire logic loopHalt,
  input wire hma_conv_s meas,
  // results toward the combiner
  output hma_conv_s conv
);
  logic [7:0] cnt;
  logic done;

  // loop pacing; the loop stands still while the combiner asks to halt
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 8'h00;
      done <= 1'b0;
    end
    else if (loopHalt)
    begin
      done <= 1'b0;
    end
    else
    begin
      done <= (cnt == 8'(GAP - 1));
      cnt <= (cnt == 8'(GAP - 1)) ? 8'h00 : cnt + 8'h01;
    end
  end

  // results mean nothing between pulses, so show garbage there
  always_comb
  begin
    conv = done ? meas : ~meas;
    conv.loopDone = done;
  end
endmodule : hma_loop_model

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import hma_pkg::*;
;
  logic clk_sys, nrst, loopHalt, alertN, overtempPinNIn, overtempOwnDrive;
  hma_req_s req;
  hma_conv_s meas, conv;
  logic [7:0] regRdata, tv;
  logic [4:0] extRequestInputs;
  logic [11:0] vf;
  int error_cnt, n_checks, seed, idx;
  localparam logic [7:0] RA [0:9] = '{ADDR_HW_INT_A, ADDR_HW_EXT_A,
    ADDR_CH_MODE, ADDR_TEMP_HI, ADDR_TEMP_LO, ADDR_CFG_TWO, 8'h00,
    ADDR_HW_INT_B, ADDR_HW_EXT_B, ADDR_CFG_ONE};
  localparam logic [7:0] RV [0:9] = '{8'h46, 8'h55, 8'h00, 8'h7F,
    8'h80, 8'h40, 8'h00, 8'h46, 8'h55, 8'h00};

  hma_alert_combiner uut (.clk_sys(clk_sys), .nrst(nrst), .req(req),
    .regRdata(regRdata), .conv(conv), .loopHalt(loopHalt),
    .extRequestInputs(extRequestInputs), .overtempPinNIn(overtempPinNIn),
    .overtempOwnDrive(overtempOwnDrive), .alertN(alertN));
  hma_loop_model #(.GAP(16)) partner (.clk_sys(clk_sys), .nrst(nrst),
    .loopHalt(loopHalt), .meas(meas), .conv(conv));

  // free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic chk_al(input logic e);
    check({7'h00, alertN}, {7'h00, e});
  endtask : chk_al

  function automatic logic [7:0] st_of(input logic [11:0] v, input logic hi);
    return hi ? {2'b00, v[11:6]} : {2'b00, v[5:0]};
  endfunction : st_of

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{1'b0, 1'b1, a, d};
    @(posedge clk_sys);
    req <= '0;
  endtask : wr

  // read data is registered, so look one step after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    check(regRdata, exp);
  endtask : rd

  // wait for loop pulses, then let status and alert settle
  task automatic wait_loop(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(posedge clk_sys);
        #1;
        k++;
      end while (conv.loopDone !== 1'b1 && k < 200);
      if (k >= 200)
      begin
        error_cnt++;
        $display("Error at %0t: loop stalled", $time);
      end
    end
    tick(2);
  endtask : wait_loop

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // hang guard, far beyond the several hundred cycles the run needs
  initial
  begin
    #200000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    seed = 196;
    error_cnt = 0;
    n_checks = 0;
    nrst = 1'b0;
    req = '0;
    meas = '0;
    extRequestInputs = 5'h07;
    overtempPinNIn = 1'b1;
    overtempOwnDrive = 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    tick(1);
    chk_al(1'b1);
    foreach (RA[i]) rd(RA[i], RV[i]);
    endt("reset");
    // one random voltage or fan error
    wr(ADDR_CFG_ONE, 8'h02);
    idx = ($random(seed) & 32'h7FFFFFFF) % 12;
    vf = 12'h001 << idx;
    @(posedge clk_sys);
    meas.vfErr <= vf;
    wait_loop(1);
    chk_al(1'b0);
    rd(ADDR_STAT_1, st_of(vf, 1'b0));
    rd(ADDR_STAT_2, st_of(vf, 1'b1));
    tick(1);
    chk_al(1'b1);
    // status reads stay a whole loop apart, the scaled-down refresh gap
    wait_loop(1);
    chk_al(1'b0);
    @(posedge clk_sys);
    meas.vfErr <= 12'h000;
    wait_loop(1);
    chk_al(1'b0);
    rd(ADDR_COPY_1, st_of(vf, 1'b0));
    rd(ADDR_COPY_2, st_of(vf, 1'b1));
    rd(ADDR_STAT_1, st_of(vf, 1'b0));
    rd(ADDR_STAT_2, st_of(vf, 1'b1));
    rd(ADDR_STAT_1, 8'h00);
    chk_al(1'b1);
    endt("status");
    // masked error still sets status but stays off the alert
    wr(ADDR_STAT_1, st_of(vf, 1'b0));
    wr(ADDR_STAT_2, st_of(vf, 1'b1));
    @(posedge clk_sys);
    meas.vfErr <= vf;
    wait_loop(1);
    chk_al(1'b1);
    rd(ADDR_COPY_1, st_of(vf, 1'b0));
    wr(ADDR_CFG_ONE, 8'h00);
    wr(ADDR_STAT_1, 8'h00);
    wr(ADDR_STAT_2, 8'h00);
    tick(2);
    chk_al(1'b1);
    wr(ADDR_CFG_ONE, 8'h02);
    tick(2);
    chk_al(1'b0);
    wr(ADDR_CFG_ONE, 8'h0A);
    tick(2);
    chk_al(1'b1);
    check({7'h00, loopHalt}, 8'h01);
    wr(ADDR_CFG_ONE, 8'h02);
    @(posedge clk_sys);
    meas.vfErr <= 12'h000;
    rd(ADDR_STAT_1, st_of(vf, 1'b0));
    rd(ADDR_STAT_2, st_of(vf, 1'b1));
    endt("mask");
    // request inputs: polarity, enables and block switch
    wr(ADDR_CH_MODE, 8'h1F);
    @(posedge clk_sys);
    extRequestInputs <= 5'h0F;
    tick(2);
    chk_al(1'b1);
    wr(ADDR_CFG_TWO, 8'h70);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_sys);
      extRequestInputs <= 5'h07 ^ (5'h01 << i);
      tick(2);
      chk_al(1'b0);
    end
    rd(ADDR_COPY_1, 8'h00);
    wr(ADDR_CH_MODE, 8'h9F);
    tick(2);
    chk_al(1'b1);
    wr(ADDR_CH_MODE, 8'h1F);
    wr(ADDR_CFG_ONE, 8'h0A);
    wr(ADDR_CH_MODE, 8'h0F);
    wr(ADDR_CFG_ONE, 8'h02);
    tick(2);
    chk_al(1'b1);
    @(posedge clk_sys);
    extRequestInputs <= 5'h07;
    wr(ADDR_CH_MODE, 8'h1F);
    endt("requests");
    // overtemp pin, own drive, thermal mask
    @(posedge clk_sys);
    overtempOwnDrive <= 1'b1;
    overtempPinNIn <= 1'b0;
    tick(3);
    rd(ADDR_COPY_2, 8'h00);
    @(posedge clk_sys);
    overtempOwnDrive <= 1'b0;
    wait_loop(1);
    rd(ADDR_COPY_2, 8'h40);
    chk_al(1'b0);
    rd(ADDR_STAT_2, 8'h40);
    rd(ADDR_COPY_2, 8'h00);
    chk_al(1'b1);
    wait_loop(1);
    rd(ADDR_COPY_2, 8'h40);
    wr(ADDR_CFG_TWO, 8'h71);
    rd(ADDR_STAT_2, 8'h40);
    wait_loop(1);
    rd(ADDR_COPY_2, 8'h40);
    chk_al(1'b1);
    @(posedge clk_sys);
    overtempPinNIn <= 1'b1;
    rd(ADDR_STAT_2, 8'h40);
    wr(ADDR_CFG_TWO, 8'h70);
    endt("overtemp");
    // internal temperature against the soft limits
    wr(ADDR_TEMP_HI, 8'h30);
    tv = 8'h31 + 8'($random(seed) & 32'h0000000F);
    @(posedge clk_sys);
    meas.intTemp <= tv;
    wait_loop(1);
    chk_al(1'b0);
    rd(ADDR_STAT_1, 8'h40);
    wait_loop(1);
    rd(ADDR_COPY_1, 8'h40);
    chk_al(1'b1);
    wr(ADDR_TEMP_HI, 8'h2F);
    wait_loop(1);
    chk_al(1'b0);
    @(posedge clk_sys);
    meas.intTemp <= 8'h20;
    rd(ADDR_STAT_1, 8'h40);
    // low side: one in-range loop first, then drop below the new low limit
    wr(ADDR_TEMP_LO, 8'h10);
    wait_loop(1);
    chk_al(1'b1);
    @(posedge clk_sys);
    meas.intTemp <= 8'hF0;
    wait_loop(1);
    chk_al(1'b0);
    rd(ADDR_STAT_1, 8'h40);
    @(posedge clk_sys);
    meas.intTemp <= 8'h20;
    endt("temperature");
    // hardware limit with its lock and re-initialize
    wr(ADDR_HW_INT_A, 8'h10);
    wr(ADDR_CFG_TWO, 8'h72);
    wr(ADDR_HW_INT_A, 8'h20);
    wr(ADDR_CFG_TWO, 8'h70);
    wr(ADDR_HW_INT_A, 8'h20);
    rd(ADDR_HW_INT_A, 8'h10);
    wait_loop(1);
    chk_al(1'b0);
    rd(ADDR_STAT_1, 8'h00);
    tick(1);
    chk_al(1'b0);
    wr(ADDR_CFG_ONE, 8'h0A);
    tick(2);
    chk_al(1'b1);
    wr(ADDR_CFG_ONE, 8'h80);
    rd(ADDR_HW_INT_A, 8'h46);
    rd(ADDR_CFG_TWO, 8'h40);
    @(posedge clk_sys);
    meas.intTemp <= 8'h00;
    endt("hardware");
    // remote readings: hardware limit, then the fault queue
    wr(ADDR_CFG_ONE, 8'h02);
    @(posedge clk_sys);
    meas.remFirstTemp <= 8'h60;
    wait_loop(1);
    chk_al(1'b0);
    wr(ADDR_CFG_ONE, 8'h0A);
    @(posedge clk_sys);
    meas.remFirstTemp <= 8'h00;
    meas.remOut <= 2'b11;
    wr(ADDR_CFG_ONE, 8'h02);
    wait_loop(2);
    rd(ADDR_COPY_1, 8'h00);
    wait_loop(1);
    rd(ADDR_COPY_1, 8'h80);
    rd(ADDR_COPY_2, 8'h80);
    chk_al(1'b0);
    @(posedge clk_sys);
    meas.remOut <= 2'b00;
    wait_loop(1);
    rd(ADDR_COPY_1, 8'h00);
    chk_al(1'b1);
    endt("remote");
    give_verdict();
  end
endmodule : testbench
